/* File: tb/mts_timer_checker.sv */
// mts_timer_checker: concurrent checks on the timer subsystem ports
// assumes a bind to mts_timer_top; one clock, async active low reset
module mts_timer_checker (
	input wire logic             clk,
	input wire logic             nrst,
	input wire logic [7:0]       address,
	input wire logic             read,
	input wire logic             write,
	input wire logic [31:0]      readdata,
	input wire logic             waitrequest,
	input wire mts_pkg::mts_pm_t pwr_mode,
	input wire logic             radio_on,
	input wire logic [2:0]       rtc_evt,
	input wire logic [7:0]       gp_evt,
	input wire logic             rat_trig,
	input wire logic [31:0]      rat_time,
	input wire logic             irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	sequence s_req_rise;
		$rose(read | write);
	endsequence
	sequence s_asleep;
		(pwr_mode >= mts_pkg::MTS_PM_STANDBY) [*4];
	endsequence
	// three write-free cycles keep a resync request out of the window
	sequence s_quiet_run;
		radio_on [*4] ##0 !$past(write) && !$past(write, 2)
			&& !$past(write, 3);
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_bus_one_wait:
	assert property (s_req_rise |-> waitrequest ##1 !waitrequest)
		else $error("request did not see exactly one wait state");
	chk_bus_idle_free:
	assert property (!(read || write) |-> !waitrequest)
		else $error("waitrequest high without a request");
	chk_unmapped_zero:
	assert property (read && !waitrequest && address >= 8'hC0
		|-> readdata == 32'h0) else $error("unmapped read not zero");
	chk_rtc_evt_pulse:
	assert property (|rtc_evt |=> rtc_evt == 3'h0)
		else $error("rtc event longer than one cycle");
	chk_gp_evt_pulse:
	assert property ((gp_evt & $past(gp_evt)) == 8'h00)
		else $error("lane timeout longer than one cycle");
	chk_gp_sleep_quiet:
	assert property (s_asleep |-> gp_evt == 8'h00)
		else $error("lane event in standby or shutdown");
	chk_irq_fall_cause:
	assert property ($fell(irq) |-> $past(write && !waitrequest
		&& (address == 8'h20 || address == 8'h24)))
		else $error("irq dropped without a status or mask write");
	chk_rat_hold_off:
	assert property (!radio_on [*3] |-> $stable(rat_time))
		else $error("radio timer moved while radio off");
	chk_rat_one_step:
	assert property (s_quiet_run |-> rat_time - $past(rat_time) <= 32'h1)
		else $error("radio timer stepped by more than one");
	chk_rat_trig_once:
	assert property (rat_trig |-> $past(radio_on) ##1 !rat_trig)
		else $error("radio trigger not a single pulse while on");
endmodule

/* File: tb/tb_top.sv */
// tb_top: self-checking bench for the timer subsystem
// assumes mts_pkg and the design files are compiled first
`include "mts_cfg.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk;
	logic             nrst;
	logic [7:0]       address;
	logic             read;
	logic             write;
	logic [31:0]      writedata;
	logic [31:0]      readdata;
	logic             waitrequest;
	mts_pkg::mts_pm_t pwr_mode;
	logic             dbg_halt;
	logic             lf_pin;
	logic             radio_on;
	logic [7:0]       evt_in;
	logic [2:0]       rtc_evt;
	logic [7:0]       gp_evt;
	logic [7:0]       gp_out;
	logic             rat_trig;
	logic [31:0]      rat_time;
	logic             irq;
	int               n_errors = 0;
	int               tests_run = 0;
	int               cyc = 0;
	int               n_rtc = 0;
	int               n_trig = 0;
	int               n_g1 = 0;
	int               n_hi = 0;
	int               evq[$];

	mts_timer_top mts_timer_top_i (.clk, .nrst, .address, .read, .write,
		.writedata, .readdata, .waitrequest, .pwr_mode, .dbg_halt,
		.lf_pin, .radio_on, .evt_in, .rtc_evt, .gp_evt, .gp_out,
		.rat_trig, .rat_time, .irq);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// event monitor: the model keeps pulse times and counts
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (gp_evt[0] === 1'b1)
			evq.push_back(cyc);
		if (gp_evt[1] === 1'b1)
			n_g1 <= n_g1 + 1;
		if (gp_out[0] === 1'b1)
			n_hi <= n_hi + 1;
		if (rtc_evt[0] === 1'b1)
			n_rtc <= n_rtc + 1;
		if (rat_trig === 1'b1)
			n_trig <= n_trig + 1;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		// hold the request until waitrequest is seen low at a rising edge
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ck_irq(input logic e);
		@(negedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		tk(80000);
		n_errors++;
		complete_run;
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [31:0] a;
		int L;
		int s;
		int g;
		logic [31:0] ra[5] = '{32'h0, 32'h4, 32'h30, 32'h24, 32'hFC};
		logic [31:0] rv[5] = '{32'h1, 32'h800000, 32'h2, 32'h0, 32'h0};
		int cc[6] = '{1, 1, 3, 1, 1, 1};
		int dh[6] = '{0, 1, 1, 0, 0, 0};
		int pm[6] = '{0, 0, 0, 3, 2, 0};
		int sp[6] = '{32'h20000, 0, 32'h20000, 0, 32'h40000, 32'h20001};
		nrst = 1'b0;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		pwr_mode = mts_pkg::MTS_PM_ACTIVE;
		dbg_halt = 1'b0;
		lf_pin = 1'b0;
		radio_on = 1'b0;
		evt_in = 8'h00;
		tk(12);
		nrst <= 1'b1;
		s = $urandom(32'hED38);
		for (int i = 0; i < 5; i++) begin
			rd(ra[i][7:0], q);
			chk("reset_value", rv[i], q);
		end
		a = $urandom;
		wr(8'h24, a);
		rd(8'h24, q);
		chk("mask", a & 32'hFFFFF, q);
		wr(8'h24, 32'h8);
		$display("test registers done");
		for (int m = 0; m < 5; m++) begin
			L = 4 + $urandom % 4;
			pwr_mode <= (m == 3) ? mts_pkg::MTS_PM_IDLE
				: mts_pkg::MTS_PM_ACTIVE;
			wr(8'h44, L);
			wr(8'h40, m << 4);
			s = evq.size();
			wr(8'h40, (m << 4) | 1);
			if (m == 4) begin
				tk(100);
				chk("edge_idle", s, evq.size());
				repeat (2 * L + 2) begin
					evt_in[0] <= 1'b1;
					tk(3);
					evt_in[0] <= 1'b0;
					tk(3);
				end
				tk(10);
				chk("edge_count", s + 2, evq.size());
			end else begin
				tk(12 * L);
				if (m == 0)
					chk("oneshot", s + 1, evq.size());
				else
					chk("period", 3 * L + 3, evq[s + 1] - evq[s]);
				// one full period of samples: pwm high only at count zero
				g = n_hi;
				tk(3 * L + 3);
				a = (m == 0) ? 0 : (m == 2) ? 3 : 3 * L + 3;
				chk("lane_out", a, n_hi - g);
				if (m == 3) begin
					evt_in[0] <= 1'b1;
					tk(6);
					evt_in[0] <= 1'b0;
					rd(8'h4C, q);
					chk("capture", 1, q <= L);
					rd(8'h20, q);
					chk("capt_stat", 32'h800, q & 32'h800);
				end
			end
			if (m == 0) begin
				ck_irq(1'b1);
				wr(8'h24, 32'h0);
				ck_irq(1'b0);
				wr(8'h24, 32'h8);
				ck_irq(1'b1);
				wr(8'h20, 32'hFFFFF);
				ck_irq(1'b0);
			end
			wr(8'h40, 32'h0);
		end
		$display("test lane modes done");
		wr(8'h54, 32'h5);
		wr(8'h50, 32'h10);
		wr(8'h50, 32'h11);
		wr(8'h44, 32'h5);
		wr(8'h40, 32'h12);
		wr(8'h40, 32'h13);
		tk(10);
		s = n_g1;
		g = evq.size();
		tk(200);
		chk("odd_lane_off", s, n_g1);
		chk("wide_runs", 1, evq.size() > g + 4);
		pwr_mode <= mts_pkg::MTS_PM_STANDBY;
		tk(4);
		s = evq.size();
		tk(200);
		chk("standby_freeze", s, evq.size());
		pwr_mode <= mts_pkg::MTS_PM_ACTIVE;
		tk(60);
		chk("active_resume", 1, evq.size() > s);
		wr(8'h40, 32'h0);
		wr(8'h50, 32'h0);
		$display("test wide and power done");
		for (int i = 0; i < 6; i++) begin
			wr(8'h00, cc[i]);
			wr(8'h04, i == 4 ? 32'h01000000 : 32'h00800000);
			wr(8'h08, i == 5 ? 32'h40 : 32'h0);
			dbg_halt <= dh[i][0];
			pwr_mode <= mts_pkg::mts_pm_t'(pm[i][1:0]);
			tk(8);
			rd(8'h10, a);
			tk(6100);
			rd(8'h10, q);
			g = q - a;
			s = (g == 2 * sp[i]) || (g == 3 * sp[i]);
			if (i < 3)
				chk("rtc_halt", 1, s);
			else
				chk("rtc_rate", 1, s);
		end
		$display("test rtc rate done");
		rd(8'h0C, a);
		rd(8'h10, q);
		wr(8'h14, {a[15:0], q[31:16]} + 32'h4);
		wr(8'h00, 32'h11);
		s = n_rtc;
		tk(12300);
		chk("rtc_cmp", s + 1, n_rtc);
		rd(8'h20, q);
		chk("rtc_stat", 32'h1, q & 32'h1);
		// pin source: each rising pin edge is one tick of inc plus cal
		wr(8'h00, 32'h5);
		rd(8'h10, a);
		repeat (3) begin
			lf_pin <= 1'b1;
			tk(4);
			lf_pin <= 1'b0;
			tk(4);
		end
		rd(8'h10, q);
		chk("rtc_pin", 32'h60003, q - a);
		wr(8'h00, 32'h11);
		$display("test rtc compare done");
		radio_on <= 1'b1;
		tk(30);
		a = rat_time;
		tk(250);
		chk("rat_rate", a + 32'hA, rat_time);
		wr(8'h2C, rat_time + 32'h28);
		s = n_trig;
		tk(1200);
		chk("rat_trig", s + 1, n_trig);
		radio_on <= 1'b0;
		tk(2);
		a = rat_time;
		tk(10000);
		chk("rat_hold", a, rat_time);
		radio_on <= 1'b1;
		tk(5);
		g = rat_time - a;
		chk("rat_resync", 1, g > 250 && g < 560);
		$display("test radio timer done");
		complete_run;
	end
endmodule

bind mts_timer_top mts_timer_checker mts_timer_checker_i (.clk, .nrst,
	.address, .read, .write, .readdata, .waitrequest, .pwr_mode,
	.radio_on, .rtc_evt, .gp_evt, .rat_trig, .rat_time, .irq);

/* File: verilog/mts_cfg.svh */
// mts_cfg.svh: offsets, field positions, reset values and timing counts
// assumes a single 100 MHz system clock drives the whole timer block
`ifndef MTS_CFG_SVH
`define MTS_CFG_SVH

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define MTS_CLK_HZ      100000000
`define MTS_LF_HZ       32768
`define MTS_LF_DIV      (`MTS_CLK_HZ / `MTS_LF_HZ)
`define MTS_RAT_HZ      4000000
`define MTS_RAT_DIV     (`MTS_CLK_HZ / `MTS_RAT_HZ)
`define MTS_GP_HZ       48000000
`define MTS_GP_DIV_MIN  ((`MTS_CLK_HZ + `MTS_GP_HZ - 1) / `MTS_GP_HZ)

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define MTS_A_CTRL      8'h00
`define MTS_A_RTC_INC   8'h04
`define MTS_A_RTC_CAL   8'h08
`define MTS_A_RTC_HI    8'h0C
`define MTS_A_RTC_LO    8'h10
`define MTS_A_RTC_CMP0  8'h14
`define MTS_A_IRQ_STAT  8'h20
`define MTS_A_IRQ_MASK  8'h24
`define MTS_A_RAT_CNT   8'h28
`define MTS_A_RAT_TRIG  8'h2C
`define MTS_A_GP_DIV    8'h30
`define MTS_A_GP_BASE   8'h40
`define MTS_A_GP_END    8'hC0

// ------------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------------
`define MTS_CTRL_RTC_EN   0
`define MTS_CTRL_DBG_RUN  1
`define MTS_CTRL_LF_PIN   2
`define MTS_CTRL_RAT_SYNC 3
`define MTS_CTRL_CH_LSB   4
`define MTS_CTRL_RST      32'h00000001
`define MTS_RTC_INC_RST   32'h00800000
`define MTS_RTC_CMP_LSB   22
`define MTS_GP_DIV_RST    8'h02
`define MTS_IRQ_W         20

`endif

/* File: verilog/mts_gp_lane.sv */
// mts_gp_lane: one general purpose down counter, 16 or 32 bits wide
// assumes tick is a one-cycle enable and evt is already synchronised
module mts_gp_lane (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 tick,
	input  wire logic                 pwr_ok,
	input  wire logic                 evt,
	input  wire mts_pkg::mts_gp_cfg_t cfg,
	output wire mts_pkg::mts_gp_sts_t sts
);

	logic [31:0] cnt_q, cnt_d, cap_q, msk, cnt_m;
	logic        run_q, run_d, evt_q, tout_q, tout_d;
	logic        capt_q, out_q, out_d, edge_r, zero, step;
	logic        is_one, is_pwm, is_etime, is_ecnt;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	assign msk      = cfg.wide ? 32'hFFFFFFFF : 32'h0000FFFF;
	assign cnt_m    = cnt_q & msk;
	assign zero     = (cnt_m == 32'h00000000);
	assign is_one   = (cfg.mode == mts_pkg::MTS_GP_ONESHOT);
	assign is_pwm   = (cfg.mode == mts_pkg::MTS_GP_PWM);
	assign is_etime = (cfg.mode == mts_pkg::MTS_GP_EDGE_TIME);
	assign is_ecnt  = (cfg.mode == mts_pkg::MTS_GP_EDGE_COUNT);
	// stopped outside active and idle, edges included
	assign edge_r   = evt & ~evt_q & pwr_ok;
	assign step     = is_ecnt ? edge_r : (tick & pwr_ok);

	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		tout_d = 1'b0;
		if (!cfg.en) begin
			cnt_d = cfg.load & msk;
			run_d = 1'b1;
		end else if (step && run_q) begin
			if (zero) begin
				tout_d = 1'b1;
				if (is_one)
					run_d = 1'b0;
				else
					cnt_d = cfg.load & msk;
			end else begin
				cnt_d = (cnt_q - 32'h00000001) & msk;
			end
		end
	end

	// pwm high while the count sits at or below the match value
	assign out_d = is_pwm ? (cfg.en && cnt_m <= (cfg.match & msk))
	                      : (cfg.en & run_q);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q  <= 32'h00000000;
			cap_q  <= 32'h00000000;
			run_q  <= 1'b0;
			evt_q  <= 1'b0;
			tout_q <= 1'b0;
			capt_q <= 1'b0;
			out_q  <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			evt_q  <= evt;
			tout_q <= tout_d;
			capt_q <= cfg.en & is_etime & edge_r;
			if (cfg.en && is_etime && edge_r)
				cap_q <= cnt_m;
			out_q  <= out_d;
		end
	end

	assign sts = '{cnt: cnt_q, cap: cap_q, tout: tout_q,
	               capt: capt_q, out: out_q};

endmodule

/* File: verilog/mts_pkg.sv */
// mts_pkg: types shared by the timer subsystem files
// assumes nothing beyond the standard language
package mts_pkg;

	typedef enum logic [1:0] {
		MTS_PM_ACTIVE,
		MTS_PM_IDLE,
		MTS_PM_STANDBY,
		MTS_PM_SHUTDOWN
	} mts_pm_t;

	typedef enum logic [2:0] {
		MTS_GP_ONESHOT,
		MTS_GP_PERIODIC,
		MTS_GP_PWM,
		MTS_GP_EDGE_TIME,
		MTS_GP_EDGE_COUNT
	} mts_gp_mode_t;

	typedef struct packed {
		logic         en;
		logic         wide;
		mts_gp_mode_t mode;
		logic [31:0]  load;
		logic [31:0]  match;
	} mts_gp_cfg_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic [31:0] cap;
		logic        tout;
		logic        capt;
		logic        out;
	} mts_gp_sts_t;

endpackage

/* File: verilog/mts_timer_top.sv */
// mts_timer_top: rtc, four split-able general purpose units, radio timer
// assumes an avalon-mm master on clk; pins arrive unsynchronised
//
// Functional notes
// - rtc is a 70-bit counter with three compare channels on lf ticks.
// - rtc counts in every power mode except shutdown.
// - a signed calibration term corrects rc oscillator drift.
// - increment per tick is programmable for non 32.768 kHz clocks.
// - rtc halts during debugger halt unless software allows running.
// - each unit runs as one 32-bit or two 16-bit counters.
// - counter ticks never exceed 48 MHz from the fast clock.
// - modes: one-shot, periodic, pwm, edge timing, edge counting.
// - counter inputs and outputs connect to the event fabric.
// - general purpose counters run only in active and idle.
// - radio timer is 32 bits, 4 MHz, giving the network time.
// - radio timer resyncs to the rtc at radio on, off, or request.
// - after resync the radio timer looks as if it never stopped.
// - radio timer compare starts the commanded action on match.
// - lf clock is nominally 32.768 kHz, internal or from a pin.
//
// Added by the designer: the Avalon-MM slave port and the address map.
`include "mts_cfg.svh"

module mts_timer_top (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [7:0]       address,
	input  wire logic             read,
	input  wire logic             write,
	input  wire logic [31:0]      writedata,
	output wire logic [31:0]      readdata,
	output wire logic             waitrequest,
	input  wire mts_pkg::mts_pm_t pwr_mode,
	input  wire logic             dbg_halt,
	input  wire logic             lf_pin,
	input  wire logic             radio_on,
	input  wire logic [7:0]       evt_in,
	output wire logic [2:0]       rtc_evt,
	output wire logic [7:0]       gp_evt,
	output wire logic [7:0]       gp_out,
	output wire logic             rat_trig,
	output wire logic [31:0]      rat_time,
	output wire logic             irq
);

	// ------------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------------
	function automatic logic gp_hit(input logic [7:0] a);
		gp_hit = (a >= `MTS_A_GP_BASE) && (a < `MTS_A_GP_END);
	endfunction

	function automatic logic [2:0] gp_lane(input logic [7:0] a);
		logic [7:0] off;
		off = a - `MTS_A_GP_BASE;
		gp_lane = off[6:4];
	endfunction

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [9:0] sy1_q, sy2_q;
	logic       lfp_q, dbg_s, lfp_s;
	logic [7:0] evt_s;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sy1_q <= 10'h000;
			sy2_q <= 10'h000;
			lfp_q <= 1'b0;
		end else begin
			sy1_q <= {dbg_halt, lf_pin, evt_in};
			sy2_q <= sy1_q;
			lfp_q <= sy2_q[8];
		end
	end

	assign evt_s = sy2_q[7:0];
	assign lfp_s = sy2_q[8];
	assign dbg_s = sy2_q[9];

	// ------------------------------------------------------------------
	// bus slave: one wait state, registered read data
	// ------------------------------------------------------------------
	logic        ack_q, wr_en, rd_ld;
	logic [31:0] rdata_q, rd_mux;

	assign waitrequest = (read | write) & ~ack_q;
	assign wr_en       = write & ack_q;
	assign rd_ld       = read & ~ack_q;
	assign readdata    = rdata_q;

	// ------------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------------
	logic [31:0]                ctrl_q, inc_q, trig_q;
	logic [31:0]                cmp_q [3];
	logic [15:0]                cal_q;
	logic [7:0]                 gdiv_q;
	logic [`MTS_IRQ_W-1:0]      stat_q, mask_q, ev;
	mts_pkg::mts_gp_cfg_t       lcfg_q [8];
	logic                       sync_wr, trig_wr;

	assign sync_wr = wr_en && address == `MTS_A_CTRL &&
	                 writedata[`MTS_CTRL_RAT_SYNC];
	assign trig_wr = wr_en && address == `MTS_A_RAT_TRIG;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= `MTS_CTRL_RST;
			inc_q  <= `MTS_RTC_INC_RST;
			cal_q  <= 16'h0000;
			trig_q <= 32'h00000000;
			gdiv_q <= `MTS_GP_DIV_RST;
			mask_q <= '0;
			for (int i = 0; i < 3; i++)
				cmp_q[i] <= 32'h00000000;
			for (int i = 0; i < 8; i++)
				lcfg_q[i] <= '0;
		end else if (wr_en) begin
			if (address == `MTS_A_CTRL)
				ctrl_q <= writedata & ~(32'h1 << `MTS_CTRL_RAT_SYNC);
			else if (address == `MTS_A_RTC_INC)
				inc_q <= writedata;
			else if (address == `MTS_A_RTC_CAL)
				cal_q <= writedata[15:0];
			else if (address >= `MTS_A_RTC_CMP0 &&
			         address < `MTS_A_IRQ_STAT)
				cmp_q[address[3:2] - 2'd1] <= writedata;
			else if (address == `MTS_A_IRQ_MASK)
				mask_q <= writedata[`MTS_IRQ_W-1:0];
			else if (trig_wr)
				trig_q <= writedata;
			else if (address == `MTS_A_GP_DIV)
				gdiv_q <= writedata[7:0];
			else if (gp_hit(address)) begin
				if (address[3:2] == 2'd0) begin
					lcfg_q[gp_lane(address)].en   <= writedata[0];
					lcfg_q[gp_lane(address)].wide <= writedata[1];
					lcfg_q[gp_lane(address)].mode <=
						mts_pkg::mts_gp_mode_t'(writedata[6:4]);
				end else if (address[3:2] == 2'd1)
					lcfg_q[gp_lane(address)].load <= writedata;
				else if (address[3:2] == 2'd2)
					lcfg_q[gp_lane(address)].match <= writedata;
			end
		end
	end

	// ------------------------------------------------------------------
	// low frequency tick: internal divider or pin clock
	// ------------------------------------------------------------------
	logic [11:0] lfdiv_q;
	logic        lf_int, lf_tick;

	assign lf_int  = (lfdiv_q == 12'(`MTS_LF_DIV - 1));
	assign lf_tick = ctrl_q[`MTS_CTRL_LF_PIN] ? (lfp_s & ~lfp_q)
	                                           : lf_int;

	// ------------------------------------------------------------------
	// real-time clock
	// ------------------------------------------------------------------
	logic [69:0] rtc_q, rtc_d;
	logic [31:0] win_q, win_d;
	logic [2:0]  rtc_hit, rtc_ev_q;
	logic        rtc_run;

	// shutdown removes the always-on domain, so the count stops there
	assign rtc_run = ctrl_q[`MTS_CTRL_RTC_EN] &&
	                 pwr_mode != mts_pkg::MTS_PM_SHUTDOWN &&
	                 (!dbg_s || ctrl_q[`MTS_CTRL_DBG_RUN]);
	assign rtc_d   = rtc_q + {38'h0, inc_q} +
	                 {{54{cal_q[15]}}, cal_q};
	assign win_q   = rtc_q[`MTS_RTC_CMP_LSB+31:`MTS_RTC_CMP_LSB];
	assign win_d   = rtc_d[`MTS_RTC_CMP_LSB+31:`MTS_RTC_CMP_LSB];

	generate
		for (genvar c = 0; c < 3; c++) begin : g_ch
			// crossing test, since a large increment may skip the value
			assign rtc_hit[c] = lf_tick && rtc_run &&
				ctrl_q[`MTS_CTRL_CH_LSB+c] &&
				win_q < cmp_q[c] && win_d >= cmp_q[c];
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lfdiv_q  <= 12'h000;
			rtc_q    <= 70'h0;
			rtc_ev_q <= 3'h0;
		end else begin
			lfdiv_q  <= lf_int ? 12'h000 : lfdiv_q + 12'h001;
			if (lf_tick && rtc_run)
				rtc_q <= rtc_d;
			rtc_ev_q <= rtc_hit;
		end
	end

	assign rtc_evt = rtc_ev_q;

	// ------------------------------------------------------------------
	// general purpose units
	// ------------------------------------------------------------------
	logic [7:0]           gdcnt_q, gdiv_eff;
	logic                 gp_tick, gp_pwr;
	mts_pkg::mts_gp_cfg_t lcfg_e [8];
	mts_pkg::mts_gp_sts_t lsts [8];

	// clamp keeps the tick at or below 48 MHz from the 100 MHz clock
	assign gdiv_eff = (gdiv_q < 8'(`MTS_GP_DIV_MIN - 1)) ?
	                  8'(`MTS_GP_DIV_MIN - 1) : gdiv_q;
	assign gp_tick  = (gdcnt_q >= gdiv_eff);
	assign gp_pwr   = pwr_mode == mts_pkg::MTS_PM_ACTIVE ||
	                  pwr_mode == mts_pkg::MTS_PM_IDLE;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			gdcnt_q <= 8'h00;
		else
			gdcnt_q <= gp_tick ? 8'h00 : gdcnt_q + 8'h01;
	end

	generate
		for (genvar i = 0; i < 8; i++) begin : g_lane
			if (i % 2 == 0) begin : g_lo
				assign lcfg_e[i] = lcfg_q[i];
			end else begin : g_hi
				// upper half is folded into the lower lane in wide mode
				always_comb begin
					lcfg_e[i]      = lcfg_q[i];
					lcfg_e[i].wide = 1'b0;
					lcfg_e[i].en   = lcfg_q[i].en &
					                 ~lcfg_q[i-1].wide;
				end
			end
			mts_gp_lane u_lane (
				.clk    (clk),
				.nrst   (nrst),
				.tick   (gp_tick),
				.pwr_ok (gp_pwr),
				.evt    (evt_s[i]),
				.cfg    (lcfg_e[i]),
				.sts    (lsts[i])
			);
			assign gp_evt[i] = lsts[i].tout;
			assign gp_out[i] = lsts[i].out;
		end
	endgenerate

	// ------------------------------------------------------------------
	// radio timer
	// ------------------------------------------------------------------
	logic [4:0]  rdiv_q;
	logic [31:0] rat_q, off_q, conv;
	logic [70:0] rat_prod;
	logic        rad_q, arm_q, fire, fire_q, rat_tick;
	logic        go_on, go_off;

	assign rat_tick = (rdiv_q == 5'(`MTS_RAT_DIV - 1));
	// rtc time in 2^-16 s units scaled to 4 MHz counts
	assign rat_prod = rtc_q[69:22] * 23'(`MTS_RAT_HZ);
	assign conv     = rat_prod[47:16];
	assign go_on    = (radio_on & ~rad_q) | (sync_wr & radio_on);
	assign go_off   = ~radio_on & rad_q;
	assign fire     = arm_q & radio_on & (rat_q == trig_q);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdiv_q <= 5'h00;
			rat_q  <= 32'h00000000;
			off_q  <= 32'h00000000;
			rad_q  <= 1'b0;
			arm_q  <= 1'b0;
			fire_q <= 1'b0;
		end else begin
			rdiv_q <= rat_tick ? 5'h00 : rdiv_q + 5'h01;
			rad_q  <= radio_on;
			if (go_off)
				off_q <= rat_q - conv;
			if (go_on)
				rat_q <= conv + off_q;
			else if (radio_on && rat_tick)
				rat_q <= rat_q + 32'h00000001;
			if (trig_wr)
				arm_q <= 1'b1;
			else if (fire)
				arm_q <= 1'b0;
			fire_q <= fire;
		end
	end

	assign rat_trig = fire_q;
	assign rat_time = rat_q;

	// ------------------------------------------------------------------
	// interrupts: set wins over a write-one clear
	// ------------------------------------------------------------------
	generate
		for (genvar i = 0; i < 8; i++) begin : g_ev
			assign ev[3+i]  = lsts[i].tout;
			assign ev[11+i] = lsts[i].capt;
		end
	endgenerate
	assign ev[2:0] = rtc_ev_q;
	assign ev[19]  = fire_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			stat_q <= '0;
		else if (wr_en && address == `MTS_A_IRQ_STAT)
			stat_q <= (stat_q & ~writedata[`MTS_IRQ_W-1:0]) | ev;
		else
			stat_q <= stat_q | ev;
	end

	assign irq = |(stat_q & mask_q);

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	mts_pkg::mts_gp_sts_t rs;
	mts_pkg::mts_gp_cfg_t rc;
	assign rs = lsts[gp_lane(address)];
	assign rc = lcfg_q[gp_lane(address)];

	always_comb begin
		rd_mux = 32'h00000000;
		if (address == `MTS_A_CTRL)
			rd_mux = ctrl_q;
		else if (address == `MTS_A_RTC_INC)
			rd_mux = inc_q;
		else if (address == `MTS_A_RTC_CAL)
			rd_mux = {16'h0000, cal_q};
		else if (address == `MTS_A_RTC_HI)
			rd_mux = rtc_q[69:38];
		else if (address == `MTS_A_RTC_LO)
			rd_mux = rtc_q[37:6];
		else if (address >= `MTS_A_RTC_CMP0 && address < `MTS_A_IRQ_STAT)
			rd_mux = (address[3:2] == 2'd0) ? 32'h00000000
			                                : cmp_q[address[3:2] - 2'd1];
		else if (address == `MTS_A_IRQ_STAT)
			rd_mux = {12'h000, stat_q};
		else if (address == `MTS_A_IRQ_MASK)
			rd_mux = {12'h000, mask_q};
		else if (address == `MTS_A_RAT_CNT)
			rd_mux = rat_q;
		else if (address == `MTS_A_RAT_TRIG)
			rd_mux = trig_q;
		else if (address == `MTS_A_GP_DIV)
			rd_mux = {24'h000000, gdiv_q};
		else if (gp_hit(address)) begin
			if (address[3:2] == 2'd0)
				rd_mux = {25'h0, rc.mode, 2'h0, rc.wide, rc.en};
			else if (address[3:2] == 2'd1)
				rd_mux = rc.load;
			else if (address[3:2] == 2'd2)
				rd_mux = rc.match;
			else
				rd_mux = (rc.mode == mts_pkg::MTS_GP_EDGE_TIME) ?
				         rs.cap : rs.cnt;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= (read | write) & ~ack_q;
			if (rd_ld)
				rdata_q <= rd_mux;
		end
	end

endmodule
